// >>> core/pmu_ctrl_defs.svh
// register offsets, field positions and reset values of the channel control block
// Function
// [RULE1] system switch bits route force/sense lines
// [RULE2] clamp enable field activates selected clamps
// [RULE3] clamp readback shows latest write source
// [RULE4] comparator outputs off at reset, enable field
// [RULE5] comparator enable readback shows latest write
// [RULE6] compare select high voltage, low current
// [RULE7] alarm clear resets all flags, every channel
// [RULE8] range code 101 disables always-on buffer
// [RULE9] code 101 leaves channel high-Z, buffer off
// [RULE10] range code 110 enables always-on buffer
// [RULE11] code 110 also forces channel high-Z
// [RULE12] host selects force voltage when enabling
// [RULE13] host rewrites function, range to resume
// [RULE14] external sense resistor only at code 100
// [RULE15] always-on mode off after power-on
// [RULE16] fields apply to every addressed channel
`ifndef PMU_CTRL_DEFS_SVH
`define PMU_CTRL_DEFS_SVH

// apb byte offsets
`define OFS_CTRL_WORD 12'h000
`define OFS_SYS_CTRL 12'h004
`define OFS_CHAN_STAT 12'h008
`define OFS_IRQ_STAT 12'h00C
`define OFS_IRQ_MASK 12'h010

// control word field positions
`define B_RDWR 28
`define B_CHAN_HI 27
`define B_CHAN_LO 24
`define B_MODE_HI 23
`define B_MODE_LO 22
`define B_DRV_HI 21
`define B_DRV_LO 20
`define B_RNG_HI 17
`define B_RNG_LO 15
`define B_SYSTEM_FORCE_LINE 11
`define B_SYSTEM_SENSE_LINE 10
`define B_CLAMP 9
`define B_CMP_OE 8
`define B_CMP_V 7
`define B_CLEAR 6

// range codes
`define RNG_EXT 3'h4
`define RNG_AON_OFF 3'h5
`define RNG_AON_ON 3'h6
`define RNG_RESET 3'h3

// system control bits
`define B_SYS_CLAMP 0
`define B_SYS_CMP_OE 1

// interrupt status bits
`define IRQ_ALARM 0
`define IRQ_AON_ON 1
`define IRQ_AON_OFF 2
`define IRQ_W 3

`endif

// >>> core/pmu_ctrl_pkg.sv
// types shared by the channel control block
package pmu_ctrl_pkg;

    // per-channel decoded controls towards the analog front end
    typedef struct packed {
        logic system_force_line_switch;
        logic system_sense_line_switch;
        logic clamp_enable;
        logic comparator_output_enable;
        logic compare_voltage;
        logic ext_buf_always_on;
        logic force_hiz;
        logic ext_sense_connect;
    } chan_ctrl_t;

    // latched alarm flags
    typedef struct packed {
        logic temp;
        logic guard;
        logic clamp;
    } alarm_flags_t;

endpackage : pmu_ctrl_pkg

// >>> core/pmu_channel_control_fields.sv
// apb register bank decoding the lower per-channel control fields
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pmu_ctrl_defs.svh"

module pmu_channel_control_fields
    import pmu_ctrl_pkg::*;
#(
    parameter int NCHAN = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // alarm events from the analog side, asynchronous
    input wire logic [2:0] alarm_event,
    // decoded per-channel controls
    output chan_ctrl_t [NCHAN-1:0] chan_ctrl,
    // latched alarm flags and the alarm pin
    output alarm_flags_t alarm_flags,
    output logic alarm_pin,
    // interrupt
    output logic irq
);

    // apb access phase strobes
    wire logic access;
    wire logic wr_en;
    wire logic rd_en;
    assign access = psel & penable;
    assign wr_en = access & pwrite;
    assign rd_en = access & ~pwrite;

    // address decode
    wire logic hit_ctrl;
    wire logic hit_sys;
    wire logic hit_stat;
    wire logic hit_irq;
    wire logic hit_mask;
    wire logic hit_any;
    assign hit_ctrl = (paddr == `OFS_CTRL_WORD);
    assign hit_sys = (paddr == `OFS_SYS_CTRL);
    assign hit_stat = (paddr == `OFS_CHAN_STAT);
    assign hit_irq = (paddr == `OFS_IRQ_STAT);
    assign hit_mask = (paddr == `OFS_IRQ_MASK);
    assign hit_any = hit_ctrl | hit_sys | hit_stat | hit_irq | hit_mask;

    // zero-wait slave; unmapped addresses answer with an error
    // a write to a read-only register is dropped without an error
    assign pready = 1'b1;
    assign pslverr = access & ~hit_any;

    // control word write: only a write with mode 00 reaches the pmu fields,
    // the readback flag and dac modes are left to other blocks
    wire logic ctrl_wr;
    assign ctrl_wr = wr_en & hit_ctrl & ~pwdata[`B_RDWR]
        & (pwdata[`B_MODE_HI:`B_MODE_LO] == 2'h0);

    // fields of the incoming word
    wire logic [3:0] chan_sel;
    wire logic [2:0] rng_code;
    wire logic clear_req;
    assign chan_sel = pwdata[`B_CHAN_HI:`B_CHAN_LO];
    assign rng_code = pwdata[`B_RNG_HI:`B_RNG_LO];
    assign clear_req = ctrl_wr & pwdata[`B_CLEAR];

    // always-on special codes
    wire logic code_aon_off;
    wire logic code_aon_on;
    assign code_aon_off = (rng_code == `RNG_AON_OFF);
    assign code_aon_on = (rng_code == `RNG_AON_ON);

    // system control word write applies to every channel at once
    wire logic sys_wr;
    assign sys_wr = wr_en & hit_sys;

    // per-channel state, one copy per channel
    logic [NCHAN-1:0] sf_q;
    logic [NCHAN-1:0] ss_q;
    logic [NCHAN-1:0] clamp_q;
    logic [NCHAN-1:0] cmp_oe_q;
    logic [NCHAN-1:0] cmp_v_q;
    logic [NCHAN-1:0] aon_q;
    logic [NCHAN-1:0] hiz_q;
    logic [NCHAN-1:0] ext_q;
    // per-channel write strobe
    logic [NCHAN-1:0] chan_wr;
    // events seen on any channel this cycle
    logic [NCHAN-1:0] aon_on_ev;
    logic [NCHAN-1:0] aon_off_ev;

    genvar g;
    generate
        for (g = 0; g < NCHAN; g++)
        begin : g_chan
            // every addressed channel takes the same field values
            assign chan_wr[g] = ctrl_wr & chan_sel[g]; // [RULE16]
            assign aon_on_ev[g] = chan_wr[g] & code_aon_on;
            assign aon_off_ev[g] = chan_wr[g] & code_aon_off;

            // system line switches follow the two switch bits directly
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    sf_q[g] <= 1'b0;
                    ss_q[g] <= 1'b0;
                end
                else if (chan_wr[g])
                begin
                    sf_q[g] <= pwdata[`B_SYSTEM_FORCE_LINE]; // [RULE1]
                    ss_q[g] <= pwdata[`B_SYSTEM_SENSE_LINE]; // [RULE1]
                end
            end

            // clamp enable: whichever word wrote last wins, so readback
            // matches the write order across both sources
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    clamp_q[g] <= 1'b0;
                else if (chan_wr[g])
                    clamp_q[g] <= pwdata[`B_CLAMP]; // [RULE2] [RULE3]
                else if (sys_wr)
                    clamp_q[g] <= pwdata[`B_SYS_CLAMP]; // [RULE2] [RULE3]
            end

            // comparator output enable, high-Z after reset
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    cmp_oe_q[g] <= 1'b0; // [RULE4]
                else if (chan_wr[g])
                    cmp_oe_q[g] <= pwdata[`B_CMP_OE]; // [RULE4] [RULE5]
                else if (sys_wr)
                    cmp_oe_q[g] <= pwdata[`B_SYS_CMP_OE]; // [RULE5]
            end

            // compare select: high voltage, low current
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    cmp_v_q[g] <= 1'b0;
                else if (chan_wr[g])
                    cmp_v_q[g] <= pwdata[`B_CMP_V]; // [RULE6]
            end

            // always-on mode of the external range buffer
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    aon_q[g] <= 1'b0; // [RULE15]
                else if (aon_on_ev[g])
                    aon_q[g] <= 1'b1; // [RULE10]
                else if (aon_off_ev[g])
                    aon_q[g] <= 1'b0; // [RULE8] [RULE9]
            end

            // either always-on code parks the channel in high-Z; any other
            // range code releases it, the host supplies the function then
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    hiz_q[g] <= 1'b0;
                else if (chan_wr[g])
                    hiz_q[g] <= code_aon_on | code_aon_off; // [RULE9] [RULE11] [RULE13]
            end

            // external sense resistor tracks the held range code; the
            // special codes are not ranges and disconnect it as well
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    ext_q[g] <= 1'b0;
                else if (chan_wr[g])
                    ext_q[g] <= (rng_code == `RNG_EXT); // [RULE14]
            end

            // pack the channel outputs, all straight from flops
            assign chan_ctrl[g].system_force_line_switch = sf_q[g];
            assign chan_ctrl[g].system_sense_line_switch = ss_q[g];
            assign chan_ctrl[g].clamp_enable = clamp_q[g];
            assign chan_ctrl[g].comparator_output_enable = cmp_oe_q[g];
            assign chan_ctrl[g].compare_voltage = cmp_v_q[g];
            assign chan_ctrl[g].ext_buf_always_on = aon_q[g];
            assign chan_ctrl[g].force_hiz = hiz_q[g];
            assign chan_ctrl[g].ext_sense_connect = ext_q[g];
        end
    endgenerate

    // two-flop synchroniser for the asynchronous alarm events;
    // only the second stage is looked at by logic
    logic [2:0] alarm_meta;
    logic [2:0] alarm_sync;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            alarm_meta <= 3'h0;
            alarm_sync <= 3'h0;
        end
        else
        begin
            alarm_meta <= alarm_event;
            alarm_sync <= alarm_meta;
        end
    end

    // latched alarm flags; clear acts regardless of channel selection,
    // but an alarm arriving in the clearing cycle still latches
    logic [2:0] alarm_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            alarm_q <= 3'h0;
        else
            alarm_q <= (alarm_q & ~{3{clear_req}}) | alarm_sync; // [RULE7]
    end
    assign alarm_flags = alarm_flags_t'(alarm_q);

    // alarm pin is a flop too, cleared together with the flags
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            alarm_pin <= 1'b0;
        else
            alarm_pin <= ((alarm_pin & ~clear_req) | (|alarm_sync)); // [RULE7]
    end

    // interrupt sources for this cycle
    // the alarm bit marks a clear request, not the alarm itself: the
    // alarm pin already reports the alarm level to the host
    wire logic [`IRQ_W-1:0] irq_src;
    assign irq_src[`IRQ_ALARM] = clear_req;
    assign irq_src[`IRQ_AON_ON] = |aon_on_ev;
    assign irq_src[`IRQ_AON_OFF] = |aon_off_ev;

    // sticky status, cleared by its own read; a new event wins the clear
    logic [`IRQ_W-1:0] irq_stat;
    wire logic irq_rd;
    assign irq_rd = rd_en & hit_irq;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_stat <= '0;
        else
            irq_stat <= (irq_stat & ~{`IRQ_W{irq_rd}}) | irq_src;
    end

    // interrupt mask, all sources blocked after reset
    logic [`IRQ_W-1:0] irq_mask;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_mask <= '0;
        else if (wr_en & hit_mask)
            irq_mask <= pwdata[`IRQ_W-1:0];
    end

    // level interrupt while any unmasked status bit stands
    assign irq = |(irq_stat & irq_mask);

    // system control readback shows channel 0; a system word lands on every channel
    wire logic [31:0] sys_view;
    assign sys_view = {30'h0, cmp_oe_q[0], clamp_q[0]};

    // channel status: one byte-lane style group of NCHAN bits per field
    wire logic [31:0] stat_view;
    assign stat_view = 32'({ext_q, hiz_q, aon_q, cmp_v_q,
        cmp_oe_q, clamp_q, ss_q, sf_q});

    // the control word itself reads back as zero: its fields are spread
    // over the channels and only the status view says which is which
    wire logic [31:0] next_prdata;
    assign next_prdata = hit_sys ? sys_view
        : hit_stat ? stat_view
        : hit_irq ? {{(32-`IRQ_W){1'b0}}, irq_stat}
        : hit_mask ? {{(32-`IRQ_W){1'b0}}, irq_mask}
        : 32'h0000_0000;

    // read data captured in the setup cycle so it stands in the access phase
    // trade-off: a status bit set during the access shows on the next read
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
            prdata <= next_prdata;
    end

endmodule : pmu_channel_control_fields
`default_nettype wire

// >>> sim/pmu_ctrl_chk_sva.sv
// port checker of the channel control block
`timescale 1ns/1ps
`default_nettype none
module pmu_ctrl_chk
    import pmu_ctrl_pkg::*;
#(
    parameter int NCHAN = 4
)
(
    // clock, reset and apb
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // observed side
    input wire logic [2:0] alarm_event,
    input wire chan_ctrl_t [NCHAN-1:0] chan_ctrl,
    input wire alarm_flags_t alarm_flags,
    input wire logic alarm_pin,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // accepted control word write
    wire cw = psel && penable && pwrite && paddr == 12'h000 && !pwdata[28] && pwdata[23:22] == 2'b00;
    // accepted system control write
    wire sw = psel && penable && pwrite && paddr == 12'h004;
    wire [2:0] rng = pwdata[17:15];
    force_switch_a: assert property (cw && pwdata[24] |=> chan_ctrl[0].system_force_line_switch == $past(pwdata[11]))
        else $error("force switch");
    clamp_word_a: assert property (cw && pwdata[24] |=> chan_ctrl[0].clamp_enable == $past(pwdata[9]))
        else $error("clamp word");
    clamp_sys_a: assert property (sw |=> chan_ctrl[0].clamp_enable == $past(pwdata[0]))
        else $error("clamp sys");
    cmp_enable_a: assert property (sw |=> chan_ctrl[0].comparator_output_enable == $past(pwdata[1]))
        else $error("cmp enable");
    cmp_select_a: assert property (cw && pwdata[24] |=> chan_ctrl[0].compare_voltage == $past(pwdata[7]))
        else $error("cmp select");
    aon_enable_a: assert property (cw && pwdata[26] && rng == 3'h6 |=> chan_ctrl[2].ext_buf_always_on && chan_ctrl[2].force_hiz)
        else $error("aon on");
    aon_disable_a: assert property (cw && pwdata[26] && rng == 3'h5 |=> !chan_ctrl[2].ext_buf_always_on && chan_ctrl[2].force_hiz)
        else $error("aon off");
    ext_sense_a: assert property (cw && pwdata[24] |=> chan_ctrl[0].ext_sense_connect == ($past(rng) == 3'h4))
        else $error("ext sense");
    alarm_clear_a: assert property ((alarm_event == 3'h0) [*3] ##0 (cw && pwdata[6]) |=> alarm_flags == 3'h0 && !alarm_pin)
        else $error("alarm clear");
    reset_idle_a: assert property ($rose(rst_b) |-> chan_ctrl == '0 && !alarm_pin && !irq)
        else $error("reset state");
    all_chan_a: assert property (cw && pwdata[27:24] == 4'hF |=> chan_ctrl[NCHAN-1].comparator_output_enable == $past(pwdata[8]))
        else $error("all channels");
    cover property (cw && rng == 3'h6);
    cover property (cw && pwdata[6]);
    cover property (irq);
endmodule : pmu_ctrl_chk
bind pmu_channel_control_fields pmu_ctrl_chk #(.NCHAN(NCHAN)) pmu_ctrl_chk_inst (.clk, .rst_b,
    .psel, .penable, .pwrite, .paddr, .pwdata, .alarm_event, .chan_ctrl, .alarm_flags,
    .alarm_pin, .irq);
`default_nettype wire

// >>> sim/pmu_alarm_src.sv
// alarm source standing in for the analog front end
`timescale 1ns/1ps
`default_nettype none
module pmu_alarm_src
(
    // clock and bench command
    input wire logic clk,
    input wire logic [2:0] alarm_req,
    // alarm levels into the block
    output logic [2:0] alarm_event
);
    // levels follow the command one edge later; the unknown before the
    // first edge is flushed while the block is still held in reset
    always @(posedge clk)
    begin
        alarm_event <= alarm_req;
    end
endmodule : pmu_alarm_src
`default_nettype wire

// >>> sim/pmu_channel_control_fields_tb_top.sv
// self-checking bench of the channel control block
`timescale 1ns/1ps
`default_nettype none
module pmu_channel_control_fields_tb_top
    import pmu_ctrl_pkg::*;
;
    // bench side signals
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, err, alarm_pin, irq;
    logic [2:0] alarm_req = 3'h0;
    logic [2:0] alarm_event;
    chan_ctrl_t [3:0] chan_ctrl;
    alarm_flags_t alarm_flags;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    pmu_channel_control_fields #(.NCHAN(4)) pmu_channel_control_fields_inst (.clk, .rst_b,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .alarm_event, .chan_ctrl, .alarm_flags, .alarm_pin, .irq);
    pmu_alarm_src pmu_alarm_src_inst (.clk, .alarm_req, .alarm_event);
    initial forever #5 clk = ~clk;
    // control word: channel mask, range code, bits 11 down to 6
    function automatic logic [31:0] cw(input logic [3:0] ch, input logic [2:0] r,
        input logic [5:0] lo);
        return {4'h0, ch, 6'h00, r, 3'h0, lo, 6'h00};
    endfunction : cw
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd
    // outputs looked at mid-cycle, once the edge's updates have landed
    task automatic pins(input logic [3:0] exp);
        @(negedge clk);
        chk({28'h0, alarm_flags, alarm_pin}, {28'h0, exp});
    endtask : pins
    task automatic irq_is(input logic exp);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irq_is
    task automatic give_verdict;
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // watchdog: the whole sequence needs about a hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(12'h008, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, 12'h000, cw(4'(1 << s), 3'h3, {s[1:0], 4'h0}));
        end
        rd(12'h008, 32'h0000_00AC);
        apb(1'b1, 12'h000, cw(4'hF, 3'h3, 6'h0E));
        rd(12'h008, 32'h000F_FF00);
        apb(1'b1, 12'h004, 32'h0);
        rd(12'h008, 32'h000F_0000);
        apb(1'b1, 12'h000, cw(4'h1, 3'h3, 6'h08));
        rd(12'h004, 32'h1);
        apb(1'b1, 12'h010, 32'h7);
        apb(1'b1, 12'h000, cw(4'h4, 3'h6, 6'h00));
        rd(12'h008, 32'h044A_0100);
        irq_is(1'b1);
        rd(12'h00C, 32'h2);
        irq_is(1'b0);
        apb(1'b1, 12'h000, cw(4'h4, 3'h4, 6'h00));
        rd(12'h008, 32'h404A_0100);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h000, cw(4'h4, 3'h5, 6'h00));
        rd(12'h008, 32'h040A_0100);
        irq_is(1'b0);
        apb(1'b1, 12'h010, 32'h4);
        irq_is(1'b1);
        rd(12'h00C, 32'h4);
        alarm_req <= 3'h7;
        repeat (4) @(posedge clk);
        alarm_req <= 3'h0;
        repeat (4) @(posedge clk);
        pins(4'hF);
        apb(1'b1, 12'h000, cw(4'h0, 3'h3, 6'h01));
        pins(4'h0);
        rd(12'h00C, 32'h1);
        // a read-back request word must leave every channel alone
        apb(1'b1, 12'h000, cw(4'h1, 3'h3, 6'h20) | 32'h1000_0000);
        rd(12'h008, 32'h040A_0100);
        // a dac mode word (mode bits 01) must leave every channel alone too
        apb(1'b1, 12'h000, cw(4'h1, 3'h3, 6'h20) | 32'h0040_0000);
        rd(12'h008, 32'h040A_0100);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rdat, 32'h0);
        give_verdict();
    end
endmodule : pmu_channel_control_fields_tb_top
`default_nettype wire
